// *** test/chan_model.sv ***
// Channel-side model: status bytes and transmit FIFO levels.
// Assumes the bench picks the FIFO fill level; statuses are fixed.
`timescale 1ns/100ps
module chan_model #(
  parameter logic [7:0] S0 = 8'h11,
  parameter logic [7:0] S1 = 8'h22,
  parameter logic [7:0] SA = 8'h33,
  parameter logic [7:0] SD = 8'h44,
  parameter logic [7:0] SF = 8'h55
) (
  // Fill level: 0 empty, 1 entry slot free, 2 full
  input  wire logic [1:0] fill_i,
  // Status and levels
  output logic      [7:0] stat0_o,
  output logic      [7:0] stat1_o,
  output logic      [7:0] stat10_o,
  output logic      [7:0] baud_high_o,
  output logic      [7:0] stat15_o,
  output logic            fifo_empty_o,
  output logic            entry_empty_o
);
  assign stat0_o       = S0;
  assign stat1_o       = S1;
  assign stat10_o      = SA;
  assign baud_high_o   = SD;
  assign stat15_o      = SF;
  // The entry slot frees before the whole FIFO does.
  assign fifo_empty_o  = (fill_i == 2'h0);
  assign entry_empty_o = (fill_i != 2'h2);
endmodule : chan_model

// *** test/sync_address_enhancement_regs_tb.sv ***
// Self-checking bench for the sync, address and enhancement bank.
// Assumes one 20 MHz clock and the channel model for status inputs.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", n, e, g); fail_count++; end end
module sync_address_enhancement_regs_tb;
  import sync_regs_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, chan_rst_i = 0, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 4'h0, rx_fifo_count_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rx_addr_i = 8'h00, rdata_o, tx_sync_o, rx_sync_o;
  logic [7:0] s0, s1, sa, sd, sf;
  logic [1:0] fill = 2'h0;
  mode_t mode_i = MODE_ASYNC;
  logic tx_buf_wr_i = 0, rx_char_load_i = 0, rx_special_i = 0, rx_all_chars_en_i = 1;
  logic closing_flag_end_i = 0, underrun_i = 0, fe, ee, addr_match_o, tbe_irq_o, dma_req_o;
  logic dtr_req_o, tx_buf_discard_o, rx_avail_irq_o, special_irq_o, rts_o, eom_clr_o;
  logic crc_preset_o, crc_poly_sel_o, auto_flag_o, rx_complete_crc_o, force_txd_high_o;
  logic [15:0] crc_preset_val_o;
  int fail_count = 0, cmp_count = 0;
  logic [3:0] slot [5] = '{4'h9, 4'h4, 4'h5, 4'hE, 4'hB};
  logic [7:0] on_v [5] = '{8'h13, 8'h24, 8'h31, 8'h46, 8'hA0};
  logic [7:0] off_v [5] = '{8'h44, 8'h11, 8'h22, 8'h33, 8'h55};

  chan_model cm (.fill_i(fill), .stat0_o(s0), .stat1_o(s1), .stat10_o(sa),
    .baud_high_o(sd), .stat15_o(sf), .fifo_empty_o(fe), .entry_empty_o(ee));
  sync_address_enhancement_regs dut (.*, .stat0_i(s0), .stat1_i(s1), .stat10_i(sa),
    .baud_high_i(sd), .stat15_i(sf), .tx_fifo_empty_i(fe), .tx_entry_empty_i(ee));

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Each pulse lasts one cycle; the registered answer is looked at one cycle later.
  `define PULSE(s) begin @(posedge clk_i); s <= 1'b1; @(posedge clk_i); s <= 1'b0; #1; end

  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wr(4'hF, 8'h00);
    mode_i <= MODE_MONO;
    wr(4'h6, 8'hA5);
    `CHK("tx_sync", 8'hA5, tx_sync_o)
    mode_i <= MODE_ASYNC; step();
    `CHK("tx_sync", 8'h00, tx_sync_o)
    mode_i <= MODE_SDLC; rx_addr_i <= 8'hA5; step();
    `CHK("match", 1'b1, addr_match_o)
    rx_addr_i <= 8'h5A; step();
    `CHK("match", 1'b0, addr_match_o)
    wr(4'h7, 8'h7E);
    wr(4'h3, 8'h13); wr(4'h4, 8'h24); wr(4'h5, 8'h31); wr(4'hA, 8'hA0);
    `CHK("rx_sync", 8'h7E, rx_sync_o)
    for (int i = 0; i < 5; i++) rd(slot[i], off_v[i]);
    rd(4'h2, 8'h00);
    wr(4'hF, 8'h01); wr(4'h7, 8'h46);
    `CHK("rx_sync", 8'h7E, rx_sync_o)
    for (int i = 0; i < 5; i++) rd(slot[i], on_v[i]);
    rd(4'hE, 8'h46);
    `PULSE(underrun_i)
    `CHK("eom", 2'h3, {eom_clr_o, crc_preset_o})
    `CHK("preset", 16'hFFFF, crc_preset_val_o)
    wr(4'h5, 8'h37); wr(4'h5, 8'h35); step(); step();
    `CHK("poly", 1'b1, crc_poly_sel_o)
    `CHK("rts", 1'b1, rts_o)
    `PULSE(closing_flag_end_i)
    `CHK("rts", 1'b0, rts_o)
    fill <= 2'h1; wr(4'h7, 8'h60);
    `CHK("tbe_dma", 2'h0, {tbe_irq_o, dma_req_o})
    `CHK("rx_crc", 1'b1, rx_complete_crc_o)
    wr(4'h7, 8'h40);
    `CHK("tbe_dma", 2'h3, {tbe_irq_o, dma_req_o})
    `CHK("auto_flag", 1'b0, auto_flag_o)
    rx_fifo_count_i <= 4'h1; `PULSE(rx_char_load_i)
    `CHK("avail", 1'b1, rx_avail_irq_o)
    wr(4'h7, 8'h48); rx_fifo_count_i <= 4'h3; `PULSE(rx_char_load_i)
    `CHK("avail", 1'b0, rx_avail_irq_o)
    rx_fifo_count_i <= 4'h4; `PULSE(rx_char_load_i)
    `CHK("avail", 1'b1, rx_avail_irq_o)
    rx_all_chars_en_i <= 1'b0; `PULSE(rx_char_load_i)
    `CHK("avail", 1'b0, rx_avail_irq_o)
    rx_all_chars_en_i <= 1'b1;
    rx_fifo_count_i <= 4'h1; rx_special_i <= 1'b1; `PULSE(rx_char_load_i)
    `CHK("special", 1'b1, special_irq_o)
    rx_special_i <= 1'b0;
    `CHK("force", 1'b1, force_txd_high_o)
    @(posedge clk_i); tx_buf_wr_i <= 1'b1; #1;
    `CHK("discard", 1'b1, tx_buf_discard_o)
    @(posedge clk_i); tx_buf_wr_i <= 1'b0;
    wr(4'h7, 8'h41);
    `PULSE(chan_rst_i)
    `CHK("auto_flag", 1'b1, auto_flag_o)
    `CHK("auto_flag", 1'b1, auto_flag_o)
    `CHK("poly", 1'b0, crc_poly_sel_o)
    rd(4'hE, 8'h00);
    fill <= 2'h0; wr(4'hE, 8'h04); wr(4'h7, 8'h40); step(); step();
    `CHK("dtr", 1'b1, dtr_req_o)
    `PULSE(tx_buf_wr_i) step(); step();
    `CHK("dtr", 1'b1, dtr_req_o)
    step();
    `CHK("dtr", 1'b0, dtr_req_o)
    wr(4'h7, 8'h50); step(); step(); step();
    `PULSE(tx_buf_wr_i)
    `CHK("dtr", 1'b0, dtr_req_o)
    summarize();
  end
endmodule : sync_address_enhancement_regs_tb

// *** verilog/sync_address_enhancement_regs.sv ***
// Sync, address and enhancement register bank of one serial channel.
// Assumes the host bus and the channel datapath share clk_i.
`timescale 1ns/100ps
module sync_address_enhancement_regs (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  chan_rst_i,
  // Register port
  input  wire logic [3:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  // Status registers; slots 4, 5, 9, B and E also read them when extended read is off
  input  wire logic [7:0]            stat0_i,
  input  wire logic [7:0]            stat1_i,
  input  wire logic [7:0]            stat10_i,
  input  wire logic [7:0]            baud_high_i,
  input  wire logic [7:0]            stat15_i,
  // Channel mode
  input  wire sync_regs_pkg::mode_t  mode_i,
  // Sync and address
  output logic      [7:0]            tx_sync_o,
  output logic      [7:0]            rx_sync_o,
  input  wire logic [7:0]            rx_addr_i,
  output logic                       addr_match_o,
  // Transmit FIFO and request
  input  wire logic                  tx_fifo_empty_i,
  input  wire logic                  tx_entry_empty_i,
  input  wire logic                  tx_buf_wr_i,
  output logic                       tbe_irq_o,
  output logic                       dma_req_o,
  output logic                       dtr_req_o,
  output logic                       tx_buf_discard_o,
  // Receive FIFO
  input  wire logic                  rx_char_load_i,
  input  wire logic                  rx_special_i,
  input  wire logic [3:0]            rx_fifo_count_i,
  input  wire logic                  rx_all_chars_en_i,
  output logic                       rx_avail_irq_o,
  output logic                       special_irq_o,
  // Transmitter controls
  input  wire logic                  closing_flag_end_i,
  input  wire logic                  underrun_i,
  output logic                       rts_o,
  output logic                       eom_clr_o,
  output logic                       crc_preset_o,
  output logic      [15:0]           crc_preset_val_o,
  output logic                       crc_poly_sel_o,
  output logic                       auto_flag_o,
  output logic                       rx_complete_crc_o,
  output logic                       force_txd_high_o
);
  import sync_regs_pkg::*;

  typedef struct packed {
    logic [7:0] rx_ctrl;
    logic [7:0] mode_ctrl;
    logic [7:0] tx_ctrl;
    logic [7:0] sync_addr;
    logic [7:0] sync_flag;
    logic [7:0] enh;
    logic [7:0] enh_img;
    logic [7:0] misc_txrx;
    logic [7:0] misc_ctrl;
    logic [7:0] ext_stat;
    logic [7:0] rdata;
    logic       rts_act;
    logic       dtr_req;
    logic [2:0] dcnt;
    logic       eom_clr;
    logic       crc_pre;
    logic       rx_avail;
    logic       special;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction : hit

  logic sdlc;
  logic tx_level;
  logic enh_sel;
  logic force_high;
  logic req_mode;

  assign sdlc     = (mode_i == MODE_SDLC);
  assign enh_sel  = st.ext_stat[ESC_ENH_SEL];
  assign req_mode = st.misc_ctrl[MCT_REQ_MODE];
  assign tx_level = st.enh[ENH_TX_LEVEL] ? tx_fifo_empty_i : tx_entry_empty_i;
  assign force_high = st.enh[ENH_FORCE_HI] && sdlc
                    && (st.misc_txrx[MSC_ENC_HI:MSC_ENC_LO] == ENC_NRZI);

  always_comb begin
    next_st = st;
    next_st.rdata    = REG_RST;
    next_st.eom_clr  = 1'b0;
    next_st.crc_pre  = 1'b0;
    next_st.rx_avail = 1'b0;
    next_st.special  = 1'b0;

    if (wr_i) begin
      if (hit(addr_i, WIDX_RX_CTRL))   next_st.rx_ctrl = wdata_i;
      if (hit(addr_i, WIDX_MODE_CTRL)) next_st.mode_ctrl = wdata_i;
      if (hit(addr_i, WIDX_TX_CTRL))   next_st.tx_ctrl = wdata_i;
      if (hit(addr_i, WIDX_SYNC_ADDR)) next_st.sync_addr = wdata_i;
      if (hit(addr_i, WIDX_MISC_TXRX)) next_st.misc_txrx = wdata_i;
      if (hit(addr_i, WIDX_MISC_CTRL)) next_st.misc_ctrl = wdata_i;
      if (hit(addr_i, WIDX_EXT_STAT))  next_st.ext_stat = wdata_i;
      if (hit(addr_i, WIDX_SYNC_FLAG)) begin
        if (enh_sel) begin
          next_st.enh     = {1'b0, wdata_i[ENH_RSVD-1:0]};
          next_st.enh_img = {1'b0, wdata_i[ENH_RSVD-1:0]};
        end else begin
          next_st.sync_flag = wdata_i;
        end
      end
    end

    if (rd_i) begin
      if (st.enh[ENH_EXT_READ]) begin
        case (addr_i)
          RIDX_SLOT9: next_st.rdata = st.rx_ctrl;
          RIDX_SLOT4: next_st.rdata = st.mode_ctrl;
          RIDX_SLOT5: next_st.rdata = st.tx_ctrl;
          RIDX_SLOTE: next_st.rdata = st.enh_img;
          RIDX_SLOTB: next_st.rdata = st.misc_txrx;
          RIDX_STAT0: next_st.rdata = stat0_i;
          RIDX_STAT1: next_st.rdata = stat1_i;
          RIDX_SLOTA: next_st.rdata = stat10_i;
          RIDX_SLOTD: next_st.rdata = baud_high_i;
          RIDX_SLOTF: next_st.rdata = stat15_i;
          default:    next_st.rdata = REG_RST;
        endcase
      end else begin
        case (addr_i)
          RIDX_SLOT9: next_st.rdata = baud_high_i;
          RIDX_SLOT4: next_st.rdata = stat0_i;
          RIDX_SLOT5: next_st.rdata = stat1_i;
          RIDX_SLOTE: next_st.rdata = stat10_i;
          RIDX_SLOTB: next_st.rdata = stat15_i;
          RIDX_STAT0: next_st.rdata = stat0_i;
          RIDX_STAT1: next_st.rdata = stat1_i;
          RIDX_SLOTA: next_st.rdata = stat10_i;
          RIDX_SLOTD: next_st.rdata = baud_high_i;
          RIDX_SLOTF: next_st.rdata = stat15_i;
          default:    next_st.rdata = REG_RST;
        endcase
      end
    end

    // request asserts at the level chosen
    if (st.dcnt != 3'h0) begin
      next_st.dcnt = st.dcnt - 3'h1;
      if (st.dcnt == 3'h1) next_st.dtr_req = 1'b0;
    end else if (req_mode && st.dtr_req && tx_buf_wr_i) begin
      // fast mode drops on the host write
      if (st.enh[ENH_REQ_FAST]) next_st.dtr_req = 1'b0;
      else next_st.dcnt = DTR_SLOW_CYC - 3'h1;
    end else begin
      next_st.dtr_req = req_mode && tx_level;
    end

    if (st.tx_ctrl[TXC_RTS]) begin
      next_st.rts_act = 1'b1;
    end else if (st.enh[ENH_AUTO_RTS] && sdlc && st.rts_act) begin
      next_st.rts_act = !closing_flag_end_i;
    end else begin
      next_st.rts_act = 1'b0;
    end

    // automatic latch clear and CRC preset
    if (underrun_i && st.enh[ENH_AUTO_EOM]) begin
      next_st.eom_clr = 1'b1;
      next_st.crc_pre = 1'b1;
    end

    if (rx_char_load_i) begin
      next_st.special = rx_special_i;
      if (st.enh[ENH_RX_LEVEL]) begin
        next_st.rx_avail = rx_all_chars_en_i && (rx_fifo_count_i == RX_HALF);
      end else begin
        next_st.rx_avail = 1'b1;
      end
    end

    if (chan_rst_i) begin
      next_st.enh_img = REG_RST;
      next_st.tx_ctrl = REG_RST;
      next_st.misc_txrx = REG_RST;
      next_st.rts_act = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  // async modes ignore the transmit sync
  assign tx_sync_o = (mode_i == MODE_ASYNC) ? REG_RST : st.sync_addr;
  assign rx_sync_o = (mode_i == MODE_ASYNC) ? REG_RST : st.sync_flag;
  assign addr_match_o = sdlc && (rx_addr_i == st.sync_addr);
  assign tbe_irq_o = tx_level;
  assign dma_req_o = tx_level;
  assign dtr_req_o = st.dtr_req;
  assign tx_buf_discard_o = force_high && tx_buf_wr_i;
  assign rx_avail_irq_o = st.rx_avail;
  assign special_irq_o = st.special;
  assign rts_o = st.rts_act;
  assign eom_clr_o = st.eom_clr;
  assign crc_preset_o = st.crc_pre;
  assign crc_preset_val_o = st.misc_txrx[MSC_PRESET] ? 16'hFFFF : 16'h0000;
  assign crc_poly_sel_o = st.tx_ctrl[TXC_POLY];
  // opening flag; early writes need no gating here.
  assign auto_flag_o = st.enh[ENH_AUTO_FLG];
  assign rx_complete_crc_o = st.enh[ENH_RX_CRC];
  assign force_txd_high_o = force_high;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  shared_enh_write_a: assert property (
    wr_i && addr_i == WIDX_SYNC_FLAG && enh_sel && !chan_rst_i
    |=> st.enh == {1'b0, $past(wdata_i[6:0])} && $stable(st.sync_flag))
    else $error("enhancement write missed");
  sync_flag_write_a: assert property (
    wr_i && addr_i == WIDX_SYNC_FLAG && !enh_sel |=> st.sync_flag == $past(wdata_i))
    else $error("sync flag write missed");
  ext_read_a: assert property (
    rd_i && addr_i == RIDX_SLOTE && st.enh[ENH_EXT_READ]
    |=> rdata_o == $past(st.enh_img) ##1 rdata_o == 8'h00 || $past(rd_i))
    else $error("extended read wrong");
  alias_read_a: assert property (
    rd_i && addr_i == RIDX_SLOT9 && !st.enh[ENH_EXT_READ] |=> rdata_o == $past(baud_high_i))
    else $error("status alias wrong");
  slow_req_a: assert property (
    req_mode && dtr_req_o && tx_buf_wr_i && st.dcnt == 3'h0 && !st.enh[ENH_REQ_FAST]
    |=> dtr_req_o [*3] ##1 !dtr_req_o)
    else $error("slow request timing wrong");
  fast_req_a: assert property (
    req_mode && dtr_req_o && tx_buf_wr_i && st.dcnt == 3'h0 && st.enh[ENH_REQ_FAST]
    |=> !dtr_req_o)
    else $error("fast request did not drop");
  rts_hold_a: assert property (
    rts_o && sdlc && st.enh[ENH_AUTO_RTS] && !closing_flag_end_i && !chan_rst_i
    |=> rts_o)
    else $error("rts dropped early");
  auto_eom_a: assert property (
    underrun_i && st.enh[ENH_AUTO_EOM] |=> eom_clr_o && crc_preset_o)
    else $error("auto eom missing");
  special_irq_a: assert property (
    rx_char_load_i && rx_special_i |=> special_irq_o)
    else $error("special interrupt missing");
  every_char_a: assert property (
    rx_char_load_i && !st.enh[ENH_RX_LEVEL] |=> rx_avail_irq_o)
    else $error("char interrupt missing");
  chan_reset_a: assert property (
    chan_rst_i && !wr_i |=> st.enh_img == 8'h00 && $stable(st.enh))
    else $error("channel reset wrong");
  discard_a: assert property (
    tx_buf_wr_i && force_high |-> tx_buf_discard_o)
    else $error("write not discarded");
  sync_addr_write_a: assert property (
    wr_i && addr_i == WIDX_SYNC_ADDR |=> st.sync_addr == $past(wdata_i))
    else $error("sync address write missed");
  tbe_level_a: assert property (
    st.enh[ENH_TX_LEVEL] && !tx_fifo_empty_i |-> !tbe_irq_o)
    else $error("transmit empty interrupt too early");
  dma_level_a: assert property (
    !st.enh[ENH_TX_LEVEL] && tx_entry_empty_i |-> dma_req_o)
    else $error("transmit request missing");
  half_full_a: assert property (
    rx_char_load_i && st.enh[ENH_RX_LEVEL]
    && !(rx_all_chars_en_i && rx_fifo_count_i == RX_HALF) |=> !rx_avail_irq_o)
    else $error("receive interrupt before half full");
  preset_value_a: assert property (
    wr_i && addr_i == WIDX_MISC_TXRX && !chan_rst_i
    |=> crc_preset_val_o == {16{$past(wdata_i[MSC_PRESET])}})
    else $error("crc preset pattern wrong");
  force_mode_a: assert property (
    !sdlc |-> !force_txd_high_o)
    else $error("forced mark outside sdlc");
  rts_follow_a: assert property (
    !st.enh[ENH_AUTO_RTS] && !chan_rst_i |=> rts_o == $past(st.tx_ctrl[TXC_RTS]))
    else $error("rts does not follow control bit");
  slow_hold_a: assert property (
    st.dcnt != 3'h0 |-> dtr_req_o)
    else $error("request dropped during countdown");
  reserved_zero_a: assert property (
    !st.enh[ENH_RSVD])
    else $error("reserved enhancement bit set");

endmodule : sync_address_enhancement_regs

// *** verilog/sync_regs_pkg.sv ***
// Constants for the sync, address and enhancement register bank.
// Assumes one channel, with the register pointer already resolved to an index.
package sync_regs_pkg;

  // Write register indices.
  localparam logic [3:0] WIDX_RX_CTRL   = 4'h3;
  localparam logic [3:0] WIDX_MODE_CTRL = 4'h4;
  localparam logic [3:0] WIDX_TX_CTRL   = 4'h5;
  localparam logic [3:0] WIDX_SYNC_ADDR = 4'h6;
  localparam logic [3:0] WIDX_SYNC_FLAG = 4'h7;
  localparam logic [3:0] WIDX_MISC_TXRX = 4'hA;
  localparam logic [3:0] WIDX_MISC_CTRL = 4'hE;
  localparam logic [3:0] WIDX_EXT_STAT  = 4'hF;

  // Read slot indices.
  localparam logic [3:0] RIDX_STAT0 = 4'h0;
  localparam logic [3:0] RIDX_STAT1 = 4'h1;
  localparam logic [3:0] RIDX_SLOT4 = 4'h4;
  localparam logic [3:0] RIDX_SLOT5 = 4'h5;
  localparam logic [3:0] RIDX_SLOT9 = 4'h9;
  localparam logic [3:0] RIDX_SLOTA = 4'hA;
  localparam logic [3:0] RIDX_SLOTB = 4'hB;
  localparam logic [3:0] RIDX_SLOTD = 4'hD;
  localparam logic [3:0] RIDX_SLOTE = 4'hE;
  localparam logic [3:0] RIDX_SLOTF = 4'hF;

  // Enhancement register fields.
  localparam int ENH_RSVD     = 7;
  localparam int ENH_EXT_READ = 6;
  localparam int ENH_TX_LEVEL = 5;
  localparam int ENH_REQ_FAST = 4;
  localparam int ENH_RX_LEVEL = 3;
  localparam int ENH_AUTO_RTS = 2;
  localparam int ENH_AUTO_EOM = 1;
  localparam int ENH_AUTO_FLG = 0;
  // The CMOS variant gives bits three and five other meanings.
  localparam int ENH_FORCE_HI = 3;
  localparam int ENH_RX_CRC   = 5;
  // Fields of the other control registers.
  localparam int ESC_ENH_SEL   = 0;
  localparam int TXC_RTS       = 1;
  localparam int TXC_POLY      = 2;
  localparam int MSC_PRESET    = 7;
  localparam int MSC_ENC_HI    = 6;
  localparam int MSC_ENC_LO    = 5;
  localparam int MCT_REQ_MODE  = 2;
  localparam logic [1:0] ENC_NRZI = 2'h1;

  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [3:0] RX_HALF     = 4'h4;
  // Slow request deactivation, in device clock periods.
  localparam logic [2:0] DTR_SLOW_CYC = 3'h4;

  typedef enum logic [2:0] {
    MODE_ASYNC, MODE_MONO, MODE_BISYNC, MODE_EXTSYNC, MODE_SDLC
  } mode_t;

endpackage : sync_regs_pkg
